// *** hw/rlu_pkg.sv ***
// Package of constants and types for the rotate-left unit.
package rlu_pkg;
  localparam int          DATA_W        = 8;
  localparam int          BANK_W        = 4;
  localparam int          FADDR_W       = 8;
  localparam int          DADDR_W       = 12;
  localparam int          MSB_POS       = 7;
  localparam logic [3:0]  OPC_HI        = 4'h3;
  localparam logic [3:0]  OPC_HI_NC     = 4'h4;
  localparam logic [1:0]  OPC_MID       = 2'h1;
  localparam int          POS_A         = 8;
  localparam int          POS_D         = 9;
  localparam logic        DEST_WORK     = 1'b0;
  localparam logic        BANK_ACCESS   = 1'b0;
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h80;
  localparam logic [3:0]  ACCESS_LO_BK  = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BK  = 4'hf;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;

  typedef enum logic [3:0] {
    RLU_DECODE  = 4'b0001,
    RLU_READ    = 4'b0010,
    RLU_PROCESS = 4'b0100,
    RLU_WRITE   = 4'b1000
  } rlu_phase_t;
endpackage : rlu_pkg

// *** hw/rlu_rot_if.sv ***
// Interface carrying operand and results between the unit and its rotator.
`timescale 1ns/1ps
interface rlu_rot_if;
  logic [7:0] operand;
  logic       carry_in;
  logic       through_carry;
  logic [7:0] result;
  logic       carry_out;
  modport core (output operand, output carry_in, output through_carry,
                input result, input carry_out);
  modport rot (input operand, input carry_in, input through_carry,
               output result, output carry_out);
endinterface : rlu_rot_if

// *** hw/rlu_rotator.sv ***
// Combinational one-bit left rotator with optional carry path.
`timescale 1ns/1ps
module rlu_rotator (
  rlu_rot_if.rot r
);
  import rlu_pkg::*;

  // Bit 0 takes the old carry or the old top bit; carry takes the old top bit in the carry form, else keeps the old carry.
  wire fill_bit = r.through_carry ? r.carry_in
                                  : r.operand[MSB_POS];
  assign r.result    = {r.operand[MSB_POS-1:0], fill_bit};
  assign r.carry_out = r.through_carry ? r.operand[MSB_POS]
                                       : r.carry_in;
endmodule : rlu_rotator

// *** hw/rlu_top.sv ***
// Rotate-left execution unit: sequencing, addressing, writeback and flags.
`timescale 1ns/1ps
module rlu_top
  import rlu_pkg::*;
(
  // Clock and reset.
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst,
  // Instruction issue.
  input  wire logic                       i_issue,
  input  wire logic [15:0]                i_instr,
  input  wire logic [rlu_pkg::BANK_W-1:0] i_bank_select_register,
  // Data memory port.
  output logic      [rlu_pkg::DADDR_W-1:0] o_mem_addr,
  output logic                            o_mem_rd,
  input  wire logic [rlu_pkg::DATA_W-1:0] i_mem_rdata,
  output logic                            o_mem_wr,
  output logic      [rlu_pkg::DATA_W-1:0] o_mem_wdata,
  // Core state.
  output logic      [rlu_pkg::DATA_W-1:0] o_working_register,
  output logic                            o_carry,
  output logic                            o_negative,
  output logic                            o_zero,
  output logic                            o_busy,
  output logic                            o_done
);
  import rlu_pkg::*;

  rlu_phase_t             phase;
  rlu_phase_t             next_phase;
  logic                   op_carry;
  logic                   op_dest;
  logic [DADDR_W-1:0]     op_addr;
  logic [DATA_W-1:0]      operand;
  logic [DATA_W-1:0]      result;
  logic                   carry_new;

  // Opcode decode: carry form and plain form share the middle bits.
  wire is_rlc  = i_instr[15:12] == OPC_HI    && i_instr[11:10] == OPC_MID;
  wire is_rlnc = i_instr[15:12] == OPC_HI_NC && i_instr[11:10] == OPC_MID;
  wire accept  = i_issue && phase == RLU_DECODE && (is_rlc || is_rlnc);

  // Access bank splits low half to bank 0 and high half to the top bank.
  wire [FADDR_W-1:0] f_addr  = i_instr[FADDR_W-1:0];
  wire [BANK_W-1:0]  acc_bk  = (f_addr < ACCESS_SPLIT) ? ACCESS_LO_BK
                                                       : ACCESS_HI_BK;
  wire [BANK_W-1:0]  bank    = (i_instr[POS_A] == BANK_ACCESS) ? acc_bk
                                 : i_bank_select_register;
  wire [DADDR_W-1:0] eff_adr = {bank, f_addr};

  rlu_rot_if rif ();
  assign rif.operand       = operand;
  assign rif.carry_in      = o_carry;
  assign rif.through_carry = op_carry;
  rlu_rotator u_rot (.r(rif));

  // Phase sequence: decode, read, process, write.
  always_comb begin
    next_phase = phase;
    case (phase)
      RLU_DECODE:  if (accept) next_phase = RLU_READ;
      RLU_READ:    next_phase = RLU_PROCESS;
      RLU_PROCESS: next_phase = RLU_WRITE;
      RLU_WRITE:   next_phase = RLU_DECODE;
      default:     next_phase = RLU_DECODE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) phase <= RLU_DECODE;
    else       phase <= next_phase;
  end

  // Latch the decoded fields and the effective address.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      op_carry <= 1'b0;
      op_dest  <= 1'b1;
      op_addr  <= '0;
    end else if (accept) begin
      op_carry <= is_rlc;
      op_dest  <= i_instr[POS_D];
      op_addr  <= eff_adr;
    end
  end

  // Memory read strobe during the read phase.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_mem_addr <= '0;
      o_mem_rd   <= 1'b0;
    end else begin
      o_mem_addr <= accept ? eff_adr : op_addr;
      o_mem_rd   <= accept;
    end
  end

  // Capture the operand, then the rotated result.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      operand   <= RESET_BYTE;
      result    <= RESET_BYTE;
      carry_new <= 1'b0;
    end else begin
      if (phase == RLU_READ) operand <= i_mem_rdata;
      if (phase == RLU_PROCESS) begin
        result    <= rif.result;
        carry_new <= rif.carry_out;
      end
    end
  end

  // Writeback and flags.
  wire wr_now = phase == RLU_WRITE;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_mem_wr           <= 1'b0;
      o_mem_wdata        <= RESET_BYTE;
      o_working_register <= RESET_BYTE;
      o_carry            <= 1'b0;
      o_negative         <= 1'b0;
      o_zero             <= 1'b0;
      o_done             <= 1'b0;
    end else begin
      o_mem_wr <= wr_now && op_dest != DEST_WORK;
      o_done   <= wr_now;
      if (wr_now) begin
        o_mem_wdata <= result;
        if (op_dest == DEST_WORK) o_working_register <= result;
        if (op_carry) o_carry <= carry_new;
        o_negative <= result[MSB_POS];
        o_zero     <= result == RESET_BYTE;
      end
    end
  end

  // Busy follows the phase that the next edge enters, so it drops at done.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) o_busy <= 1'b0;
    else       o_busy <= next_phase != RLU_DECODE;
  end

  // Rotator results against the operand and carry that fed them.
  chk_carry_rotate: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    phase == RLU_PROCESS && op_carry |=> result ==
      {$past(operand[6:0]), $past(o_carry)} && carry_new == $past(operand[7]))
    else $error("carry rotate result wrong");
  chk_plain_rotate: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    phase == RLU_PROCESS && !op_carry |=> result ==
      {$past(operand[6:0]), $past(operand[7])})
    else $error("plain rotate result wrong");
  chk_operand_take: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    phase == RLU_READ |=> operand == $past(i_mem_rdata))
    else $error("operand not taken in read phase");

  // Flags: carry only from the carry form, N and Z from every result.
  chk_plain_carry: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    wr_now && !op_carry |=> $stable(o_carry))
    else $error("plain rotate changed carry");
  chk_carry_update: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    wr_now && op_carry |=> o_carry == $past(carry_new))
    else $error("carry flag not updated by carry rotate");
  chk_flags_nz: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    o_done |-> o_zero == (o_mem_wdata == RESET_BYTE) &&
      o_negative == o_mem_wdata[7])
    else $error("negative or zero flag wrong");

  // Writeback goes to exactly one destination.
  chk_dest_working: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    wr_now && op_dest == DEST_WORK |=> !o_mem_wr &&
      o_working_register == $past(result))
    else $error("working register writeback wrong");
  chk_dest_file: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    wr_now && op_dest != DEST_WORK |=> o_mem_wr &&
      o_mem_wdata == $past(result) && $stable(o_working_register))
    else $error("file writeback wrong");
  chk_work_hold: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !(wr_now && op_dest == DEST_WORK) |=> $stable(o_working_register))
    else $error("working register changed without writeback");

  // Operand address from the access bank or the bank select register.
  chk_bank_access: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    accept && i_instr[POS_A] == BANK_ACCESS |=>
      o_mem_addr[11:8] == ($past(i_instr[7]) ? ACCESS_HI_BK : ACCESS_LO_BK))
    else $error("access bank address wrong");
  chk_bank_select: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    accept && i_instr[POS_A] != BANK_ACCESS |=>
      o_mem_addr[11:8] == $past(i_bank_select_register))
    else $error("banked address wrong");

  // Sequencing: four phases, single-cycle pulses, no issue while busy.
  chk_phase_len: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    accept |=> o_mem_rd ##3 o_done)
    else $error("phase sequence length wrong");
  chk_busy_span: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    accept |=> o_busy [*3] ##1 !o_busy)
    else $error("busy span wrong");
  chk_read_pulse: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    o_mem_rd |=> !o_mem_rd)
    else $error("read strobe longer than one cycle");
  chk_done_pulse: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    o_done |=> !o_done)
    else $error("done pulse longer than one cycle");
  chk_busy_refuse: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    o_busy |=> !o_mem_rd)
    else $error("issue taken while busy");
endmodule : rlu_top

// *** verif/test_rotate_left_unit.sv ***
// Self-checking bench for the rotate-left execution unit.
`timescale 1ns/1ps
module test_rotate_left_unit;
  import rlu_pkg::*;
  typedef struct packed {
    logic [7:0] res;
    logic [7:0] work;
    logic       wr;
    logic       c;
    logic       n;
    logic       z;
  } rlu_exp_t;
  logic        i_sys_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_issue = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic [3:0]  i_bank_select_register = 4'h0;
  logic [11:0] o_mem_addr;
  logic        o_mem_rd, o_mem_wr, o_carry, o_negative, o_zero;
  logic [7:0]  o_mem_wdata, o_working_register, rd_byte = 8'h00;
  logic        o_busy, o_done, m_c = 1'b0;
  logic [7:0]  m_w = 8'h00;
  // Read data is only valid while a read is requested.
  wire  [7:0]  i_mem_rdata = o_mem_rd ? rd_byte : ~rd_byte;
  int          err_total = 0, checked = 0, seed = 84;
  logic [31:0] r;
  rlu_exp_t    q_res[$];
  logic [11:0] q_addr[$];

  rlu_top dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_issue(i_issue),
    .i_instr(i_instr), .i_bank_select_register(i_bank_select_register),
    .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .i_mem_rdata(i_mem_rdata),
    .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata),
    .o_working_register(o_working_register), .o_carry(o_carry),
    .o_negative(o_negative), .o_zero(o_zero), .o_busy(o_busy),
    .o_done(o_done));

  // Clock of 50 ns period.
  always #25 i_sys_clk = ~i_sys_clk;

  task automatic cmp_b(input string nm, input logic [11:0] e, g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_b

  task automatic end_sim;
    $display("Counts: checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // Issues one rotate, notes expectations, offers a refused issue meanwhile.
  task automatic run_op(input logic cf, d, a, input logic [7:0] f,
                        input logic [3:0] bk, input logic [7:0] v);
    rlu_exp_t e;
    int       n;
    e.res = {v[6:0], cf ? m_c : v[7]};
    if (cf) m_c = v[7];
    if (!d) m_w = e.res;
    e.work = m_w;
    e.wr = d;
    e.c = m_c;
    e.n = e.res[7];
    e.z = (e.res == 8'h00);
    q_res.push_back(e);
    q_addr.push_back(a ? {bk, f} : {(f < ACCESS_SPLIT) ? ACCESS_LO_BK
                                    : ACCESS_HI_BK, f});
    i_instr = {cf ? OPC_HI : OPC_HI_NC, OPC_MID, d, a, f};
    i_bank_select_register = bk;
    rd_byte = v;
    i_issue = 1'b1;
    @(negedge i_sys_clk);
    cmp_b("busy", 12'h001, {11'h000, o_busy});
    i_instr = ~i_instr;
    i_bank_select_register = ~bk;
    repeat (2) @(negedge i_sys_clk);
    i_issue = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 8) begin
      @(negedge i_sys_clk);
      n++;
    end
    cmp_b("latency", 12'h001, n[11:0]);
  endtask : run_op

  // Watches reads and completions against the oldest notes.
  always @(negedge i_sys_clk) begin : mon
    rlu_exp_t e;
    if (!i_rst && o_mem_rd === 1'b1) begin
      cmp_b("address", q_addr.size() ? q_addr.pop_front() : 12'hxxx,
            o_mem_addr);
    end
    if (!i_rst && o_done === 1'b1) begin
      e = q_res.size() ? q_res.pop_front() : 'x;
      cmp_b("write", {11'h000, e.wr}, {11'h000, o_mem_wr});
      if (e.wr) begin
        cmp_b("wdata", {4'h0, e.res}, {4'h0, o_mem_wdata});
      end
      cmp_b("working", {4'h0, e.work}, {4'h0, o_working_register});
      cmp_b("carry", {11'h000, e.c}, {11'h000, o_carry});
      cmp_b("nz", {10'h000, e.n, e.z},
            {10'h000, o_negative, o_zero});
      cmp_b("busy", 12'h000, {11'h000, o_busy});
    end
  end

  // Watchdog that ends a hung run.
  initial begin
    repeat (1000) @(posedge i_sys_clk);
    err_total++;
    end_sim();
  end

  initial begin
    repeat (20) @(negedge i_sys_clk);
    i_rst = 1'b0;
    cmp_b("reset state", 12'h000,
          {o_working_register, o_carry, o_busy, o_mem_rd, o_done});
    @(negedge i_sys_clk);
    run_op(1'b1, 1'b0, 1'b0, 8'h10, 4'h3, 8'he6);
    run_op(1'b0, 1'b1, 1'b0, 8'h80, 4'h3, 8'hab);
    run_op(1'b1, 1'b1, 1'b0, 8'h7f, 4'h5, 8'h80);
    run_op(1'b0, 1'b0, 1'b1, 8'hff, 4'ha, 8'h00);
    $display("Directed rotates done");
    i_instr = 16'h5600;
    i_issue = 1'b1;
    @(negedge i_sys_clk);
    cmp_b("foreign busy", 12'h000, {11'h000, o_busy});
    i_instr = 16'h3300;
    @(negedge i_sys_clk);
    cmp_b("foreign busy", 12'h000, {11'h000, o_busy});
    i_issue = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    $display("Foreign opcode test done");
    repeat (40) begin
      r = $random(seed);
      run_op(r[0], r[1], r[2], r[15:8], r[19:16], r[27:20]);
    end
    repeat (2) @(negedge i_sys_clk);
    cmp_b("pending", 12'h000,
          12'(q_res.size() + q_addr.size()));
    $display("Random rotates done");
    end_sim();
  end
endmodule : test_rotate_left_unit
